/* verilog/flrd_params.svh */
// Constants of the fault log read-out formatter
// Behaviour
// - Block bytes 71 to 237 carry cyclic telemetry.
// - First cyclic byte is loop entry at pointer.
// - Each next cyclic byte steps one position lower.
// - Loop holds 54 positions; 0 wraps to 53.
// - Pointer 8 yields temp status, temp high, low.
// - Positions 0 and 1 hold die temperature.
// - Positions 2 to 13 hold channel 0 group.
// - Positions 14-16 input voltage and status; 17 zero.
// - Channels 1-3 groups start at 18, 30, 42.
// - Block byte 0 returns the fault-time pointer.
// - Bytes 1-6 return 41-bit timestamp, LSB first.
// - Bytes 7-58 return peaks and minimums, low first.
// - Bytes 59-70 return per-channel status bytes.
// - Bus byte numbers are log index plus one.
// - Bytes 238-254 zero; last read releases lock.
// - Loop refreshed per converter result while unlocked.
`ifndef FLRD_PARAMS_SVH
`define FLRD_PARAMS_SVH
`define FLRD_LOOP_LAST 6'h35
`define FLRD_PRE_LAST 8'h46
`define FLRD_CYC_FIRST 8'h47
`define FLRD_CYC_LAST 8'hED
`define FLRD_BLOCK_LAST 8'hFE
`define FLRD_STAMP_FIRST 8'h01
`define FLRD_STAMP_LAST 8'h06
`define FLRD_EXTR_FIRST 8'h07
`define FLRD_STAT_FIRST 8'h3B
`define FLRD_CH0_BASE 6'h02
`define FLRD_VIN_BASE 6'h0E
`define FLRD_CH1_BASE 6'h12
`define FLRD_GROUP_LEN 6'h0C
`define FLRD_ZERO_POS 6'h11
`define FLRD_FIFO_DEPTH 4
`define FLRD_STAMP_STEP_US 200
`endif

/* verilog/flrd_pkg.sv */
// Types of the fault log read-out formatter
package flrd_pkg;
  typedef struct packed {
    logic [15:0] vout;
    logic [7:0] vstat;
    logic [7:0] vendor;
    logic [15:0] temp;
    logic [7:0] tstat;
    logic [7:0] istat;
    logic [15:0] iout;
    logic [15:0] pout;
  } flrd_chan_s;
  typedef struct packed {
    flrd_chan_s [3:0] ch;
    logic [15:0] die_temp;
    logic [15:0] vin;
    logic [7:0] vin_stat;
  } flrd_telem_s;
  typedef struct packed {
    logic [15:0] vpk;
    logic [15:0] vmin;
    logic [15:0] tpk;
    logic [15:0] tmin;
    logic [15:0] ipk;
    logic [15:0] imin;
  } flrd_extr_s;
  typedef struct packed {
    flrd_extr_s [3:0] ch;
    logic [15:0] vin_pk;
    logic [15:0] vin_min;
  } flrd_peaks_s;
  typedef struct packed {
    logic [7:0] bus_num;
    logic [7:0] data;
    logic last;
  } flrd_byte_s;
  typedef enum logic [3:0] {
    FLRD_IDLE = 4'h1,
    FLRD_PRE = 4'h2,
    FLRD_CYC = 4'h4,
    FLRD_PAD = 4'h8
  } flrd_phase_e;
endpackage

/* verilog/flrd_readout.sv */
// Fault log read-out formatter with its output FIFO
`timescale 1ns/1ps
`include "flrd_params.svh"

module flrd_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 4
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int CW = $clog2(DEPTH + 1);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [CW-1:0] cnt;
    logic vld;
  } flrd_fifo_state_s;
  flrd_fifo_state_s s_q;
  flrd_fifo_state_s s_d;
  logic push;
  logic pop;

  assign in_ready_out = s_q.cnt < CW'(DEPTH);
  assign push = in_valid_in && in_ready_out;
  assign pop = s_q.vld && out_ready_in;
  assign out_valid_out = s_q.vld;
  assign out_data_out = s_q.mem[0];

  // Shift toward the head so the head is always a flop
  always_comb
  begin
    s_d = s_q;
    if (pop)
    begin
      for (int i = 0; i < DEPTH - 1; i++)
      begin
        s_d.mem[i] = s_q.mem[i+1];
      end
      s_d.mem[DEPTH-1] = '0;
      s_d.cnt = s_q.cnt - CW'(1);
    end
    if (push)
    begin
      s_d.mem[s_d.cnt] = in_data_in;
      s_d.cnt = s_d.cnt + CW'(1);
    end
    s_d.vld = s_d.cnt != '0;
  end

  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end
endmodule

module flrd_readout (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic conv_done_in,
  input wire flrd_pkg::flrd_telem_s telem_in,
  input wire flrd_pkg::flrd_peaks_s peaks_in,
  input wire logic [40:0] stamp_in,
  input wire logic fault_in,
  input wire logic lock_set_in,
  input wire logic read_start_in,
  output logic rd_valid_out,
  input wire logic rd_ready_in,
  output flrd_pkg::flrd_byte_s rd_byte_out,
  output logic ram_lock_out,
  output logic busy_out
);
  typedef struct packed {
    flrd_pkg::flrd_phase_e phase;
    logic [7:0] idx;
    logic [5:0] walk;
    logic [5:0] wptr;
    logic [5:0] ptr;
    logic lock;
    logic busy;
    logic [40:0] stamp;
    flrd_pkg::flrd_peaks_s peaks;
    logic [3:0][2:0][7:0] stat;
    logic [53:0][7:0] loop;
  } flrd_state_s;
  flrd_state_s s_q;
  flrd_state_s s_d;
  flrd_pkg::flrd_byte_s push_byte;
  logic push_ready;
  logic push;
  logic last_pop;
  logic conv_wr;

  function automatic logic [7:0] flrd_lohi(input logic [15:0] w, input logic hi);
    flrd_lohi = hi ? w[15:8] : w[7:0];
  endfunction

  function automatic logic [5:0] flrd_step_down(input logic [5:0] p);
    flrd_step_down = (p == 6'h00) ? `FLRD_LOOP_LAST : p - 6'h01;
  endfunction

  // Loop position to live telemetry byte
  // loop position map
  function automatic logic [7:0] flrd_loop_byte(input logic [5:0] pos,
                                                input flrd_pkg::flrd_telem_s t);
    logic [5:0] off;
    logic [1:0] c;
    flrd_pkg::flrd_chan_s ch;
    off = 6'h00;
    c = 2'h0;
    flrd_loop_byte = 8'h00;
    if (pos < `FLRD_CH0_BASE)
    begin
      flrd_loop_byte = flrd_lohi(t.die_temp, pos[0]);
    end
    else if (pos >= `FLRD_VIN_BASE && pos < `FLRD_CH1_BASE)
    begin
      if (pos < `FLRD_ZERO_POS - 6'h01)
      begin
        flrd_loop_byte = flrd_lohi(t.vin, pos[0]);
      end
      else if (pos == `FLRD_ZERO_POS - 6'h01)
      begin
        flrd_loop_byte = t.vin_stat;
      end
    end
    else
    begin
      if (pos < `FLRD_VIN_BASE)
      begin
        off = pos - `FLRD_CH0_BASE;
      end
      else
      begin
        c = 2'(((pos - `FLRD_CH1_BASE) / `FLRD_GROUP_LEN) + 6'h01);
        off = (pos - `FLRD_CH1_BASE) % `FLRD_GROUP_LEN;
      end
      ch = t.ch[c];
      unique case (off)
        6'h00, 6'h01: flrd_loop_byte = flrd_lohi(ch.vout, off[0]);
        6'h02: flrd_loop_byte = ch.vstat;
        6'h03: flrd_loop_byte = ch.vendor;
        6'h04, 6'h05: flrd_loop_byte = flrd_lohi(ch.temp, off[0]);
        6'h06: flrd_loop_byte = ch.tstat;
        6'h07: flrd_loop_byte = ch.istat;
        6'h08, 6'h09: flrd_loop_byte = flrd_lohi(ch.iout, off[0]);
        default: flrd_loop_byte = flrd_lohi(ch.pout, off[0]);
      endcase
    end
  endfunction

  // Preamble byte from the fault snapshot
  // preamble byte map
  function automatic logic [7:0] flrd_pre_byte(input flrd_state_s s);
    logic [7:0] k;
    logic [15:0] w;
    logic [1:0] c;
    logic [1:0] j;
    flrd_pkg::flrd_extr_s e;
    k = 8'h00;
    w = 16'h0000;
    c = 2'h0;
    j = 2'h0;
    flrd_pre_byte = 8'h00;
    if (s.idx < `FLRD_STAMP_FIRST)
    begin
      flrd_pre_byte = {2'h0, s.ptr};
    end
    else if (s.idx < `FLRD_STAMP_LAST)
    begin
      flrd_pre_byte = 8'(s.stamp >> (6'(s.idx - `FLRD_STAMP_FIRST) * 6'h08));
    end
    else if (s.idx == `FLRD_STAMP_LAST)
    begin
      flrd_pre_byte = {7'h00, s.stamp[40]};
    end
    else if (s.idx < `FLRD_STAT_FIRST)
    begin
      k = s.idx - `FLRD_EXTR_FIRST;
      if (k >= 8'h0C && k < 8'h10)
      begin
        w = k[1] ? s.peaks.vin_min : s.peaks.vin_pk;
      end
      else
      begin
        if (k >= 8'h10)
        begin
          c = 2'(((k - 8'h10) / 8'h0C) + 8'h01);
          k = (k - 8'h10) % 8'h0C;
        end
        e = s.peaks.ch[c];
        unique case (k[3:1])
          3'h0: w = e.vpk;
          3'h1: w = e.vmin;
          3'h2: w = e.tpk;
          3'h3: w = e.tmin;
          3'h4: w = e.ipk;
          default: w = e.imin;
        endcase
      end
      flrd_pre_byte = flrd_lohi(w, k[0]);
    end
    else
    begin
      c = 2'((s.idx - `FLRD_STAT_FIRST) / 8'h03);
      j = 2'((s.idx - `FLRD_STAT_FIRST) % 8'h03);
      flrd_pre_byte = s.stat[c][j];
    end
  endfunction

  assign push = (s_q.phase != flrd_pkg::FLRD_IDLE) && push_ready;
  assign last_pop = rd_valid_out && rd_ready_in && rd_byte_out.last;
  assign conv_wr = conv_done_in && !s_q.lock;

  always_comb
  begin
    push_byte.bus_num = s_q.idx + 8'h01;
    push_byte.last = s_q.idx == `FLRD_BLOCK_LAST;
    push_byte.data = 8'h00;
    unique case (s_q.phase)
      flrd_pkg::FLRD_PRE: push_byte.data = flrd_pre_byte(s_q);
      flrd_pkg::FLRD_CYC: push_byte.data = s_q.loop[s_q.walk];
      default: push_byte.data = 8'h00;
    endcase
  end

  always_comb
  begin
    s_d = s_q;
    if (conv_wr)
    begin
      s_d.wptr = (s_q.wptr == `FLRD_LOOP_LAST) ? 6'h00 : s_q.wptr + 6'h01;
      s_d.loop[s_d.wptr] = flrd_loop_byte(s_d.wptr, telem_in);
    end
    if (fault_in && !s_q.lock && !s_q.busy)
    begin
      s_d.ptr = s_d.wptr;
      s_d.stamp = stamp_in;
      s_d.peaks = peaks_in;
      for (int c = 0; c < 4; c++)
      begin
        s_d.stat[c][0] = telem_in.ch[c].vstat;
        s_d.stat[c][1] = telem_in.ch[c].istat;
        s_d.stat[c][2] = telem_in.ch[c].tstat;
      end
    end
    // final byte read releases lock, set wins
    if (last_pop)
    begin
      s_d.lock = 1'b0;
    end
    if (lock_set_in || (fault_in && !s_q.busy))
    begin
      s_d.lock = 1'b1;
    end
    unique case (s_q.phase)
      flrd_pkg::FLRD_IDLE:
      begin
        if (read_start_in)
        begin
          s_d.phase = flrd_pkg::FLRD_PRE;
          s_d.idx = 8'h00;
        end
      end
      flrd_pkg::FLRD_PRE:
      begin
        if (push)
        begin
          s_d.idx = s_q.idx + 8'h01;
          if (s_q.idx == `FLRD_PRE_LAST)
          begin
            s_d.phase = flrd_pkg::FLRD_CYC;
            s_d.walk = s_q.ptr;
          end
        end
      end
      flrd_pkg::FLRD_CYC:
      begin
        if (push)
        begin
          s_d.idx = s_q.idx + 8'h01;
          s_d.walk = flrd_step_down(s_q.walk);
          if (s_q.idx == `FLRD_CYC_LAST)
          begin
            s_d.phase = flrd_pkg::FLRD_PAD;
          end
        end
      end
      flrd_pkg::FLRD_PAD:
      begin
        if (push)
        begin
          s_d.idx = s_q.idx + 8'h01;
          if (s_q.idx == `FLRD_BLOCK_LAST)
          begin
            s_d.phase = flrd_pkg::FLRD_IDLE;
          end
        end
      end
    endcase
    s_d.busy = (s_d.phase != flrd_pkg::FLRD_IDLE) || rd_valid_out;
  end

  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      s_q <= '0;
      s_q.phase <= flrd_pkg::FLRD_IDLE;
      s_q.wptr <= `FLRD_LOOP_LAST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign ram_lock_out = s_q.lock;
  assign busy_out = s_q.busy;

  // one byte per bus byte through the FIFO
  flrd_fifo #(
    .WIDTH($bits(flrd_pkg::flrd_byte_s)),
    .DEPTH(`FLRD_FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .in_valid_in(s_q.phase != flrd_pkg::FLRD_IDLE),
    .in_ready_out(push_ready),
    .in_data_in(push_byte),
    .out_valid_out(rd_valid_out),
    .out_ready_in(rd_ready_in),
    .out_data_out(rd_byte_out)
  );

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (rst_in);

  sequence s_push_at(logic [7:0] i);
    push && s_q.idx == i;
  endsequence
  sequence s_cyc_push;
    push && s_q.phase == flrd_pkg::FLRD_CYC;
  endsequence

  first_cyc_byte_a: assert property (s_push_at(`FLRD_CYC_FIRST) |->
    push_byte.data == s_q.loop[s_q.ptr] && s_q.walk == s_q.ptr)
    else $error("first cyclic byte not at pointer");
  walk_backward_a: assert property (s_cyc_push ##0 (s_q.walk != 6'h00) |=>
    s_q.walk == $past(s_q.walk) - 6'h01)
    else $error("cyclic walk did not step down");
  walk_wrap_a: assert property (s_cyc_push ##0 (s_q.walk == 6'h00) |=>
    s_q.walk == 6'h35)
    else $error("cyclic walk did not wrap to 53");
  cyc_region_a: assert property (push && s_q.idx >= 8'h47 && s_q.idx <= 8'hED |->
    s_q.phase == flrd_pkg::FLRD_CYC)
    else $error("cyclic region misplaced");
  pad_zero_a: assert property (push && s_q.idx > 8'hED |->
    push_byte.data == 8'h00)
    else $error("pad byte not zero");
  lock_release_a: assert property (last_pop && !lock_set_in && !fault_in |=>
    !ram_lock_out)
    else $error("lock not released by final byte");
  pre_pointer_a: assert property (s_push_at(8'h00) |->
    push_byte.data == {2'h0, s_q.ptr})
    else $error("byte 0 is not the pointer");
  stamp_top_a: assert property (s_push_at(8'h06) |->
    push_byte.data == {7'h00, s_q.stamp[40]})
    else $error("timestamp top byte wrong");
  bus_num_a: assert property (push |-> push_byte.bus_num == s_q.idx + 8'h01)
    else $error("bus byte number not index plus one");
  order_a: assert property (push ##1 push |-> s_q.idx == $past(s_q.idx) + 8'h01)
    else $error("block bytes out of order");
  refresh_a: assert property (conv_wr |=> s_q.loop[s_q.wptr] ==
    flrd_loop_byte(s_q.wptr, $past(telem_in)))
    else $error("loop not refreshed");
  frozen_a: assert property (s_q.lock && !last_pop |=> $stable(s_q.loop))
    else $error("locked loop changed");
  zero_pos_a: assert property (conv_wr && s_d.wptr == 6'h11 |=>
    s_q.loop[6'h11] == 8'h00)
    else $error("position 17 not zero");
endmodule

/* sim/flrd_host_model.sv */
// Bus host model that drains the fault log byte stream
`timescale 1ns/1ps
module flrd_host_model (
  input wire logic sys_clk_in,
  input wire logic [1:0] mode_in,
  output logic rd_ready_out
);
  logic [31:0] lf_q;
  initial
  begin
    lf_q = 32'h5A5A1234;
    rd_ready_out = 1'b0;
  end
  always @(negedge sys_clk_in)
  begin
    lf_q = {lf_q[30:0], lf_q[31] ^ lf_q[21] ^ lf_q[1] ^ lf_q[0]};
    rd_ready_out <= (mode_in == 2'h0) || (mode_in == 2'h1 && lf_q[3]);
  end
endmodule

/* sim/tb_fault_log_block_readout.sv */
// Self-checking bench of the fault log read-out formatter
`timescale 1ns/1ps
module tb_fault_log_block_readout;
  logic sys_clk_in;
  logic rst_in;
  logic conv_done_in;
  flrd_pkg::flrd_telem_s telem_in;
  flrd_pkg::flrd_peaks_s peaks_in;
  logic [40:0] stamp_in;
  logic fault_in;
  logic lock_set_in;
  logic read_start_in;
  logic rd_valid_out;
  logic rd_ready_in;
  flrd_pkg::flrd_byte_s rd_byte_out;
  logic ram_lock_out;
  logic busy_out;
  logic [1:0] mode;
  int n_mismatch;
  int n_compared;
  int cyc;
  int rx_idx;
  int p;
  int pl [4] = '{8, 0, 53, 13};
  logic [31:0] seed;
  logic [447:0] rbuf;
  logic [7:0] loop_m [54];
  logic [5:0] wp;
  logic lock_m;
  logic [7:0] ptr_m;
  flrd_pkg::flrd_telem_s snp_t;
  flrd_pkg::flrd_peaks_s snp_p;
  logic [40:0] snp_s;

  flrd_readout i_dut (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .conv_done_in(conv_done_in),
    .telem_in(telem_in),
    .peaks_in(peaks_in),
    .stamp_in(stamp_in),
    .fault_in(fault_in),
    .lock_set_in(lock_set_in),
    .read_start_in(read_start_in),
    .rd_valid_out(rd_valid_out),
    .rd_ready_in(rd_ready_in),
    .rd_byte_out(rd_byte_out),
    .ram_lock_out(ram_lock_out),
    .busy_out(busy_out)
  );

  flrd_host_model i_host (
    .sys_clk_in(sys_clk_in),
    .mode_in(mode),
    .rd_ready_out(rd_ready_in)
  );

  function automatic logic [31:0] lfsr(logic [31:0] s);
    for (int i = 0; i < 32; i++)
      s = s[0] ? (s >> 1) ^ 32'h80200003 : s >> 1;
    return s;
  endfunction

  function automatic logic [7:0] pos_byte(flrd_pkg::flrd_telem_s t, int q);
    int c;
    int o;
    logic [15:0] w;
    if (q < 2)
      return q == 1 ? t.die_temp[15:8] : t.die_temp[7:0];
    if (q == 14 || q == 15)
      return q == 15 ? t.vin[15:8] : t.vin[7:0];
    if (q == 16)
      return t.vin_stat;
    if (q == 17)
      return 8'h00;
    c = q < 18 ? 0 : (q - 18) / 12 + 1;
    o = q < 18 ? q - 2 : (q - 18) % 12;
    case (o / 2)
      0: w = t.ch[c].vout;
      1: w = {t.ch[c].vendor, t.ch[c].vstat};
      2: w = t.ch[c].temp;
      3: w = {t.ch[c].istat, t.ch[c].tstat};
      4: w = t.ch[c].iout;
      default: w = t.ch[c].pout;
    endcase
    return o % 2 == 1 ? w[15:8] : w[7:0];
  endfunction

  function automatic logic [7:0] blk(int i);
    int w;
    logic [15:0] v;
    flrd_pkg::flrd_extr_s e;
    if (i == 0)
      return ptr_m;
    if (i < 7)
      return 8'(snp_s >> (8 * (i - 1)));
    if (i < 59)
    begin
      w = (i - 7) / 2;
      e = snp_p.ch[w < 8 ? 0 : (w - 8) / 6 + 1];
      case (w < 6 ? w : w == 6 ? 8 : w == 7 ? 9 : (w - 8) % 6)
        0: v = e.vpk;
        1: v = e.vmin;
        2: v = e.tpk;
        3: v = e.tmin;
        4: v = e.ipk;
        5: v = e.imin;
        8: v = snp_p.vin_pk;
        default: v = snp_p.vin_min;
      endcase
      return (i - 7) % 2 == 1 ? v[15:8] : v[7:0];
    end
    if (i < 71)
    begin
      w = (i - 59) / 3;
      case ((i - 59) % 3)
        0: return snp_t.ch[w].vstat;
        1: return snp_t.ch[w].istat;
        default: return snp_t.ch[w].tstat;
      endcase
    end
    if (i < 238)
      return loop_m[(int'(ptr_m) + 216 - (i - 71)) % 54];
    return 8'h00;
  endfunction

  task automatic chk(string what, logic [40:0] seen, logic [40:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    if (n_mismatch == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic rnd();
    for (int i = 0; i < 14; i++)
    begin
      seed = lfsr(seed);
      rbuf[i * 32 +: 32] = seed;
    end
  endtask

  task automatic evt(int k);
    @(negedge sys_clk_in);
    {read_start_in, lock_set_in, fault_in} = 3'(1 << k);
    @(negedge sys_clk_in);
    {read_start_in, lock_set_in, fault_in} = 3'h0;
  endtask

  task automatic conv();
    @(negedge sys_clk_in);
    rnd();
    telem_in = flrd_pkg::flrd_telem_s'(rbuf[$bits(telem_in)-1:0]);
    conv_done_in = 1'b1;
    if (!lock_m)
    begin
      wp = wp == 6'h35 ? 6'h00 : wp + 6'h01;
      loop_m[wp] = pos_byte(telem_in, int'(wp));
    end
    @(negedge sys_clk_in);
    conv_done_in = 1'b0;
  endtask

  task automatic do_reset();
    rst_in = 1'b1;
    repeat (20) @(negedge sys_clk_in);
    rst_in = 1'b0;
    wp = 6'h35;
    lock_m = 1'b0;
    for (int i = 0; i < 54; i++)
      loop_m[i] = 8'h00;
    chk("reset state", 41'({rd_valid_out, ram_lock_out, busy_out}), 41'h0);
  endtask

  task automatic read_all();
    rx_idx = 0;
    evt(2);
    chk("busy", 41'(busy_out), 41'h1);
    repeat (30) @(negedge sys_clk_in);
    evt(2);
    if (mode == 2'h2)
    begin
      chk("stalled count", 41'(rx_idx), 41'h0);
      chk("stalled valid", 41'(rd_valid_out), 41'h1);
      mode = 2'h1;
    end
    for (int i = 0; i < 3000 && (rx_idx < 255 || busy_out !== 1'b0); i++)
      @(negedge sys_clk_in);
    lock_m = 1'b0;
    chk("count", 41'(rx_idx), 41'hFF);
    chk("lock", 41'(ram_lock_out), 41'h0);
    chk("valid", 41'(rd_valid_out), 41'h0);
  endtask

  always @(posedge sys_clk_in)
    if (rd_valid_out === 1'b1 && rd_ready_in === 1'b1)
    begin
      if (rx_idx < 71)
        chk("preamble", 41'(rd_byte_out.data), 41'(blk(rx_idx)));
      else
        chk("log byte", 41'(rd_byte_out.data), 41'(blk(rx_idx)));
      chk("bus_num", 41'(rd_byte_out.bus_num), 41'(rx_idx + 1));
      chk("last", 41'(rd_byte_out.last), 41'(rx_idx == 254));
      rx_idx++;
    end

  initial
  begin
    sys_clk_in = 1'b0;
    forever #10 sys_clk_in = ~sys_clk_in;
  end

  always @(posedge sys_clk_in)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      n_mismatch++;
      results();
    end
  end

  initial
  begin
    {conv_done_in, fault_in, lock_set_in, read_start_in} = 4'h0;
    telem_in = '0;
    peaks_in = '0;
    stamp_in = '0;
    mode = 2'h0;
    seed = 32'hBD374933;
    n_mismatch = 0;
    n_compared = 0;
    cyc = 0;
    rx_idx = 0;
    ptr_m = 8'h00;
    for (int s = 0; s < 5; s++)
    begin
      seed = lfsr(seed);
      p = s == 4 ? int'(seed % 54) : pl[s];
      do_reset();
      repeat (p + 55) conv();
      rnd();
      peaks_in = flrd_pkg::flrd_peaks_s'(rbuf[$bits(peaks_in)-1:0]);
      stamp_in = rbuf[447:407];
      snp_t = telem_in;
      snp_p = peaks_in;
      snp_s = stamp_in;
      ptr_m = 8'(p);
      lock_m = 1'b1;
      evt(0);
      chk("fault lock", 41'(ram_lock_out), 41'h1);
      stamp_in = ~stamp_in;
      evt(0);
      repeat (3) conv();
      mode = 2'(s % 3);
      read_all();
    end
    repeat (5) conv();
    evt(1);
    lock_m = 1'b1;
    chk("set lock", 41'(ram_lock_out), 41'h1);
    repeat (2) conv();
    mode = 2'h0;
    read_all();
    results();
  end
endmodule
